/* File: inc/irfl_defines.vh */
// constants for the interrupt request flag logic
`ifndef IRFL_DEFINES_VH
`define IRFL_DEFINES_VH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IRFL_CLK_MHZ 25
`define IRFL_CLKS_PER_MC 4
`define IRFL_C3_PHASE 8'h02
`define IRFL_PIN_IDLE 1'b1
`define IRFL_NUM_SRC 12
// ----------------------------------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IRFL_IDX_TIMER_CTRL 6'h00
`define IRFL_IDX_EXT_FLAG 6'h01
`define IRFL_IDX_CNTC_MODE 6'h02
`define IRFL_IDX_CNTC_CTRL 6'h03
`define IRFL_IDX_UART_CTRL 6'h04
`define IRFL_IDX_UART2_CTRL 6'h05
`define IRFL_IDX_WDOG_CTRL 6'h06
`define IRFL_IDX_IRQ_EN 6'h07
`define IRFL_IDX_EXTRA_EN 6'h08
`define IRFL_IDX_PRIO 6'h09
`define IRFL_IDX_EXTRA_PRIO 6'h0a
`define IRFL_IDX_EVT_STATUS 6'h0b
`define IRFL_IDX_EVT_MASK 6'h0c
`define IRFL_IDX_PENDING 6'h0d
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IRFL_TC_EXT0_TRIG 0
`define IRFL_TC_EXT0_FLAG 1
`define IRFL_TC_EXT1_TRIG 2
`define IRFL_TC_EXT1_FLAG 3
`define IRFL_TC_TA_OVF 5
`define IRFL_TC_TB_OVF 7
`define IRFL_EXF_LSB 4
`define IRFL_ACS_LSB 4
`define IRFL_CC_OVF 7
`define IRFL_CC_CAP 6
`define IRFL_UC_RX 0
`define IRFL_UC_TX 1
`define IRFL_WD_FLAG 3
`define IRFL_IE_GLOBAL 7
`define IRFL_RST_BYTE 8'h00
`define IRFL_RST_SRC 12'h000
// ----------------------------------------------------------------
// source indices in fixed polling order, and vectors
// ----------------------------------------------------------------
`define IRFL_SRC_EXT0 0
`define IRFL_SRC_TA 1
`define IRFL_SRC_EXT1 2
`define IRFL_SRC_TB 3
`define IRFL_SRC_EXT2 7
`define IRFL_VEC_EXT0 16'h0003
`define IRFL_VEC_TA 16'h000b
`define IRFL_VEC_EXT1 16'h0013
`define IRFL_VEC_TB 16'h001b
`define IRFL_VEC_UART 16'h0023
`define IRFL_VEC_CNTC 16'h002b
`define IRFL_VEC_UART2 16'h003b
`define IRFL_VEC_EXT2 16'h0043
`define IRFL_VEC_EXT3 16'h004b
`define IRFL_VEC_EXT4 16'h0053
`define IRFL_VEC_EXT5 16'h005b
`define IRFL_VEC_WDOG 16'h0063
`endif

/* File: src/irfl_pin_sync.v */
// three-stage synchroniser with agreement filter for pins
`timescale 1ns/1ps
`include "irfl_defines.vh"
module irfl_pin_sync #(
    parameter WIDTH = 6
) (
    mclk,
    rst_n,
    pinRaw,
    pinLvl
);
input wire mclk;
input wire rst_n;
input wire [WIDTH-1:0] pinRaw;
output reg [WIDTH-1:0] pinLvl;

reg [WIDTH-1:0] s1_ff;
reg [WIDTH-1:0] s2_ff;
reg [WIDTH-1:0] s3_ff;

// ----------------------------------------------------------------
// sync chain
// ----------------------------------------------------------------
// level accepted once stages two and three agree
always @(posedge mclk) begin
    if (!rst_n) begin
        s1_ff <= {WIDTH{`IRFL_PIN_IDLE}};
        s2_ff <= {WIDTH{`IRFL_PIN_IDLE}};
        s3_ff <= {WIDTH{`IRFL_PIN_IDLE}};
        pinLvl <= {WIDTH{`IRFL_PIN_IDLE}};
    end else begin
        s1_ff <= pinRaw;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        pinLvl <= (s2_ff & s3_ff) | (pinLvl & (s2_ff ^ s3_ff));
    end
end
endmodule // irfl_pin_sync

/* File: src/irfl_core.v */
// interrupt request flags, enables, polling and wishbone registers
`timescale 1ns/1ps
`include "irfl_defines.vh"
// Contract
// - twelve sources: flag, priority, vector, enable
// - ext 0/1 edge or level per select
// - high then low sample sets flag
// - ext 0/1 flags timer control; 2-5 ext
// - ext 0/1 edge flag cleared on service
// - level still low raises request again
// - ext 2-5 falling edge only
// - ext 2-5 software clear, optional auto-clear
// - timer overflow set, cleared on service
// - counter c request ORs two flags
// - watchdog flag bit 3, enable bit 4
// - uart flags cleared only by software
// - every flag writable by software
// - individual enables plus global enable
// - pins sampled at third machine state
// - fixed order resolves equal priority
module irfl_core #(
    parameter CLKS_PER_MC = `IRFL_CLKS_PER_MC
) (
    mclk,
    rst_n,
    wbCycI,
    wbStbI,
    wbWeI,
    wbAdrI,
    wbSelI,
    wbDatI,
    wbDatO,
    wbAckO,
    extIrqPinN,
    timerAOvfI,
    timerBOvfI,
    counterCOvfI,
    counterCCapI,
    watchdogTimeoutI,
    uartRxI,
    uartTxI,
    uart2RxI,
    uart2TxI,
    svcEnterI,
    svcSrcI,
    irqReqO,
    irqSrcO,
    irqVecO,
    irqHighO,
    irqO
);
input wire mclk;
input wire rst_n;
input wire wbCycI;
input wire wbStbI;
input wire wbWeI;
input wire [7:0] wbAdrI;
input wire [3:0] wbSelI;
input wire [31:0] wbDatI;
output reg [31:0] wbDatO;
output reg wbAckO;
input wire [5:0] extIrqPinN;
input wire timerAOvfI;
input wire timerBOvfI;
input wire counterCOvfI;
input wire counterCCapI;
input wire watchdogTimeoutI;
input wire uartRxI;
input wire uartTxI;
input wire uart2RxI;
input wire uart2TxI;
input wire svcEnterI;
input wire [3:0] svcSrcI;
output reg irqReqO;
output reg [3:0] irqSrcO;
output reg [15:0] irqVecO;
output reg irqHighO;
output reg irqO;

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg [7:0] mcPhase_ff;
reg c3En_ff;
reg [5:0] extSample_ff;
reg ext0TriggerSelect_ff;
reg ext1TriggerSelect_ff;
reg ext0RequestFlag_ff;
reg ext1RequestFlag_ff;
reg [3:0] extRequestFlag_ff;
reg [3:0] autoClearSelect_ff;
reg timerAOverflowFlag_ff;
reg timerBOverflowFlag_ff;
reg counterCOverflowFlag_ff;
reg counterCCaptureFlag_ff;
reg uartReceiveFlag_ff;
reg uartTransmitFlag_ff;
reg secondUartReceiveFlag_ff;
reg secondUartTransmitFlag_ff;
reg watchdogTimeoutFlag_ff;
reg [7:0] irqEnable_ff;
reg [4:0] extraIrqEnable_ff;
reg [7:0] prio_ff;
reg [4:0] extraPrio_ff;
reg [11:0] evtStatus_ff;
reg [11:0] evtMask_ff;
reg [11:0] reqPrev_ff;
reg [31:0] rdData;
reg [3:0] bestIdx;
reg [15:0] bestVec;
reg [11:0] pickSet;
integer i;
wire [5:0] pinLvl;
wire [5:0] extFall;
wire [11:0] req;
wire [11:0] srcEn;
wire [11:0] srcPrio;
wire [11:0] gated;
wire [11:0] hiGated;
wire [11:0] svcHit;
wire [11:0] evtRise;
wire [5:0] idx;
wire busReq;
wire wrStb;
wire wrByte0;
wire [11:0] wrMask;
wire ext0Set;
wire ext0Clr;
wire ext1Set;
wire ext1Clr;

// ----------------------------------------------------------------
// flag next-value helper
// ----------------------------------------------------------------
// hardware set wins over software write, which wins over auto clear
function nxtFlag;
    input cur;
    input swWr;
    input swVal;
    input hwClr;
    input hwSet;
    begin
        if (hwSet) begin
            nxtFlag = 1'b1;
        end else if (swWr) begin
            nxtFlag = swVal;
        end else if (hwClr) begin
            nxtFlag = 1'b0;
        end else begin
            nxtFlag = cur;
        end
    end
endfunction

// ----------------------------------------------------------------
// machine cycle timing and pin sampling
// ----------------------------------------------------------------
irfl_pin_sync #(
    .WIDTH(6)
) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinRaw(extIrqPinN),
    .pinLvl(pinLvl)
);

// phase counter with a one-cycle strobe at the third state
always @(posedge mclk) begin
    if (!rst_n) begin
        mcPhase_ff <= 8'h00;
        c3En_ff <= 1'b0;
    end else begin
        if (mcPhase_ff == CLKS_PER_MC - 1) begin
            mcPhase_ff <= 8'h00;
        end else begin
            mcPhase_ff <= mcPhase_ff + 8'h01;
        end
        c3En_ff <= (mcPhase_ff == `IRFL_C3_PHASE);
    end
end

// one sample per machine cycle, kept for edge compare
always @(posedge mclk) begin
    if (!rst_n) begin
        extSample_ff <= {6{`IRFL_PIN_IDLE}};
    end else if (c3En_ff) begin
        extSample_ff <= pinLvl;
    end
end

// high sample followed by a low sample
assign extFall = c3En_ff ? (extSample_ff & ~pinLvl) : 6'h00;

// ----------------------------------------------------------------
// wishbone decode
// ----------------------------------------------------------------
assign idx = wbAdrI[7:2];
assign busReq = wbCycI & wbStbI;
// writes take effect on the edge that sees ack high
assign wrStb = busReq & wbWeI & wbAckO;
assign wrByte0 = wrStb & wbSelI[0];
assign wrMask = {{4{wbSelI[1]}}, {8{wbSelI[0]}}};
assign svcHit = svcEnterI ? (12'h001 << svcSrcI) : `IRFL_RST_SRC;

// ----------------------------------------------------------------
// external 0 and 1 flags
// ----------------------------------------------------------------
// edge mode sets on fall; level mode tracks the pin each machine cycle
assign ext0Set = ext0TriggerSelect_ff ? extFall[0]
                 : (c3En_ff & ~pinLvl[0]);
assign ext0Clr = ext0TriggerSelect_ff ? svcHit[`IRFL_SRC_EXT0]
                 : (c3En_ff & pinLvl[0]);
assign ext1Set = ext1TriggerSelect_ff ? extFall[1]
                 : (c3En_ff & ~pinLvl[1]);
assign ext1Clr = ext1TriggerSelect_ff ? svcHit[`IRFL_SRC_EXT1]
                 : (c3En_ff & pinLvl[1]);

// timer control register contents
always @(posedge mclk) begin
    if (!rst_n) begin
        ext0TriggerSelect_ff <= 1'b0;
        ext1TriggerSelect_ff <= 1'b0;
        ext0RequestFlag_ff <= 1'b0;
        ext1RequestFlag_ff <= 1'b0;
        timerAOverflowFlag_ff <= 1'b0;
        timerBOverflowFlag_ff <= 1'b0;
    end else begin
        if (wrByte0 && idx == `IRFL_IDX_TIMER_CTRL) begin
            ext0TriggerSelect_ff <= wbDatI[`IRFL_TC_EXT0_TRIG];
            ext1TriggerSelect_ff <= wbDatI[`IRFL_TC_EXT1_TRIG];
        end
        ext0RequestFlag_ff <= nxtFlag(ext0RequestFlag_ff,
            wrByte0 && idx == `IRFL_IDX_TIMER_CTRL,
            wbDatI[`IRFL_TC_EXT0_FLAG], ext0Clr, ext0Set);
        ext1RequestFlag_ff <= nxtFlag(ext1RequestFlag_ff,
            wrByte0 && idx == `IRFL_IDX_TIMER_CTRL,
            wbDatI[`IRFL_TC_EXT1_FLAG], ext1Clr, ext1Set);
        timerAOverflowFlag_ff <= nxtFlag(timerAOverflowFlag_ff,
            wrByte0 && idx == `IRFL_IDX_TIMER_CTRL,
            wbDatI[`IRFL_TC_TA_OVF],
            svcHit[`IRFL_SRC_TA], timerAOvfI);
        timerBOverflowFlag_ff <= nxtFlag(timerBOverflowFlag_ff,
            wrByte0 && idx == `IRFL_IDX_TIMER_CTRL,
            wbDatI[`IRFL_TC_TB_OVF],
            svcHit[`IRFL_SRC_TB], timerBOvfI);
    end
end

// ----------------------------------------------------------------
// external 2 to 5 flags
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_ext_hi
        // falling edge only, cleared by software or auto clear
        always @(posedge mclk) begin
            if (!rst_n) begin
                extRequestFlag_ff[g] <= 1'b0;
            end else begin
                extRequestFlag_ff[g] <= nxtFlag(extRequestFlag_ff[g],
                    wrByte0 && idx == `IRFL_IDX_EXT_FLAG,
                    wbDatI[`IRFL_EXF_LSB + g],
                    svcHit[`IRFL_SRC_EXT2 + g] & autoClearSelect_ff[g],
                    extFall[2 + g]);
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// peripheral flags and configuration registers
// ----------------------------------------------------------------
// no hardware clear on any of these flags
always @(posedge mclk) begin
    if (!rst_n) begin
        counterCOverflowFlag_ff <= 1'b0;
        counterCCaptureFlag_ff <= 1'b0;
        uartReceiveFlag_ff <= 1'b0;
        uartTransmitFlag_ff <= 1'b0;
        secondUartReceiveFlag_ff <= 1'b0;
        secondUartTransmitFlag_ff <= 1'b0;
        watchdogTimeoutFlag_ff <= 1'b0;
    end else begin
        counterCOverflowFlag_ff <= nxtFlag(counterCOverflowFlag_ff,
            wrByte0 && idx == `IRFL_IDX_CNTC_CTRL,
            wbDatI[`IRFL_CC_OVF], 1'b0, counterCOvfI);
        counterCCaptureFlag_ff <= nxtFlag(counterCCaptureFlag_ff,
            wrByte0 && idx == `IRFL_IDX_CNTC_CTRL,
            wbDatI[`IRFL_CC_CAP], 1'b0, counterCCapI);
        uartReceiveFlag_ff <= nxtFlag(uartReceiveFlag_ff,
            wrByte0 && idx == `IRFL_IDX_UART_CTRL,
            wbDatI[`IRFL_UC_RX], 1'b0, uartRxI);
        uartTransmitFlag_ff <= nxtFlag(uartTransmitFlag_ff,
            wrByte0 && idx == `IRFL_IDX_UART_CTRL,
            wbDatI[`IRFL_UC_TX], 1'b0, uartTxI);
        secondUartReceiveFlag_ff <= nxtFlag(secondUartReceiveFlag_ff,
            wrByte0 && idx == `IRFL_IDX_UART2_CTRL,
            wbDatI[`IRFL_UC_RX], 1'b0, uart2RxI);
        secondUartTransmitFlag_ff <= nxtFlag(secondUartTransmitFlag_ff,
            wrByte0 && idx == `IRFL_IDX_UART2_CTRL,
            wbDatI[`IRFL_UC_TX], 1'b0, uart2TxI);
        watchdogTimeoutFlag_ff <= nxtFlag(watchdogTimeoutFlag_ff,
            wrByte0 && idx == `IRFL_IDX_WDOG_CTRL,
            wbDatI[`IRFL_WD_FLAG], 1'b0, watchdogTimeoutI);
    end
end

// enables, priorities and auto clear selects
always @(posedge mclk) begin
    if (!rst_n) begin
        autoClearSelect_ff <= 4'h0;
        irqEnable_ff <= `IRFL_RST_BYTE;
        extraIrqEnable_ff <= 5'h00;
        prio_ff <= `IRFL_RST_BYTE;
        extraPrio_ff <= 5'h00;
    end else if (wrByte0) begin
        case (idx)
            `IRFL_IDX_CNTC_MODE: begin
                autoClearSelect_ff <= wbDatI[`IRFL_ACS_LSB+3:`IRFL_ACS_LSB];
            end
            `IRFL_IDX_IRQ_EN: begin
                irqEnable_ff <= wbDatI[7:0];
            end
            `IRFL_IDX_EXTRA_EN: begin
                extraIrqEnable_ff <= wbDatI[4:0];
            end
            `IRFL_IDX_PRIO: begin
                prio_ff <= {1'b0, wbDatI[6:0]};
            end
            `IRFL_IDX_EXTRA_PRIO: begin
                extraPrio_ff <= wbDatI[4:0];
            end
            default: begin
                autoClearSelect_ff <= autoClearSelect_ff;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// request gating and polling
// ----------------------------------------------------------------
assign req = {watchdogTimeoutFlag_ff, extRequestFlag_ff,
              secondUartReceiveFlag_ff | secondUartTransmitFlag_ff,
              counterCOverflowFlag_ff | counterCCaptureFlag_ff,
              uartReceiveFlag_ff | uartTransmitFlag_ff,
              timerBOverflowFlag_ff, ext1RequestFlag_ff,
              timerAOverflowFlag_ff, ext0RequestFlag_ff};
assign srcEn = {extraIrqEnable_ff, irqEnable_ff[6:0]};
assign srcPrio = {extraPrio_ff, prio_ff[6:0]};
// individual enable, then global enable blocks everything
assign gated = req & srcEn
               & {12{irqEnable_ff[`IRFL_IE_GLOBAL]}};
assign hiGated = gated & srcPrio;

// high level first, lowest index wins within a level
always @* begin
    pickSet = (|hiGated) ? hiGated : gated;
    bestIdx = 4'h0;
    for (i = `IRFL_NUM_SRC - 1; i >= 0; i = i - 1) begin
        if (pickSet[i]) begin
            bestIdx = i[3:0];
        end
    end
    case (bestIdx)
        4'h0: bestVec = `IRFL_VEC_EXT0;
        4'h1: bestVec = `IRFL_VEC_TA;
        4'h2: bestVec = `IRFL_VEC_EXT1;
        4'h3: bestVec = `IRFL_VEC_TB;
        4'h4: bestVec = `IRFL_VEC_UART;
        4'h5: bestVec = `IRFL_VEC_CNTC;
        4'h6: bestVec = `IRFL_VEC_UART2;
        4'h7: bestVec = `IRFL_VEC_EXT2;
        4'h8: bestVec = `IRFL_VEC_EXT3;
        4'h9: bestVec = `IRFL_VEC_EXT4;
        4'ha: bestVec = `IRFL_VEC_EXT5;
        default: bestVec = `IRFL_VEC_WDOG;
    endcase
end

// registered request to the core
always @(posedge mclk) begin
    if (!rst_n) begin
        irqReqO <= 1'b0;
        irqSrcO <= 4'h0;
        irqVecO <= 16'h0000;
        irqHighO <= 1'b0;
    end else begin
        irqReqO <= |gated;
        irqSrcO <= bestIdx;
        irqVecO <= bestVec;
        irqHighO <= |hiGated;
    end
end

// ----------------------------------------------------------------
// event status, mask and interrupt line
// ----------------------------------------------------------------
assign evtRise = req & ~reqPrev_ff;

// rising requests set sticky bits, write one clears, set wins
always @(posedge mclk) begin
    if (!rst_n) begin
        reqPrev_ff <= `IRFL_RST_SRC;
        evtStatus_ff <= `IRFL_RST_SRC;
        evtMask_ff <= `IRFL_RST_SRC;
        irqO <= 1'b0;
    end else begin
        reqPrev_ff <= req;
        if (wrStb && idx == `IRFL_IDX_EVT_STATUS) begin
            evtStatus_ff <= (evtStatus_ff & ~(wbDatI[11:0] & wrMask))
                            | evtRise;
        end else begin
            evtStatus_ff <= evtStatus_ff | evtRise;
        end
        if (wrStb && idx == `IRFL_IDX_EVT_MASK) begin
            evtMask_ff <= (wbDatI[11:0] & wrMask) | (evtMask_ff & ~wrMask);
        end
        irqO <= |(evtStatus_ff & evtMask_ff);
    end
end

// ----------------------------------------------------------------
// read mux and ack
// ----------------------------------------------------------------
always @* begin
    rdData = 32'h0000_0000;
    case (idx)
        `IRFL_IDX_TIMER_CTRL: begin
            rdData[`IRFL_TC_EXT0_TRIG] = ext0TriggerSelect_ff;
            rdData[`IRFL_TC_EXT0_FLAG] = ext0RequestFlag_ff;
            rdData[`IRFL_TC_EXT1_TRIG] = ext1TriggerSelect_ff;
            rdData[`IRFL_TC_EXT1_FLAG] = ext1RequestFlag_ff;
            rdData[`IRFL_TC_TA_OVF] = timerAOverflowFlag_ff;
            rdData[`IRFL_TC_TB_OVF] = timerBOverflowFlag_ff;
        end
        `IRFL_IDX_EXT_FLAG: begin
            rdData[`IRFL_EXF_LSB+3:`IRFL_EXF_LSB] = extRequestFlag_ff;
        end
        `IRFL_IDX_CNTC_MODE: begin
            rdData[`IRFL_ACS_LSB+3:`IRFL_ACS_LSB] = autoClearSelect_ff;
        end
        `IRFL_IDX_CNTC_CTRL: begin
            rdData[`IRFL_CC_OVF] = counterCOverflowFlag_ff;
            rdData[`IRFL_CC_CAP] = counterCCaptureFlag_ff;
        end
        `IRFL_IDX_UART_CTRL: begin
            rdData[`IRFL_UC_RX] = uartReceiveFlag_ff;
            rdData[`IRFL_UC_TX] = uartTransmitFlag_ff;
        end
        `IRFL_IDX_UART2_CTRL: begin
            rdData[`IRFL_UC_RX] = secondUartReceiveFlag_ff;
            rdData[`IRFL_UC_TX] = secondUartTransmitFlag_ff;
        end
        `IRFL_IDX_WDOG_CTRL: begin
            rdData[`IRFL_WD_FLAG] = watchdogTimeoutFlag_ff;
        end
        `IRFL_IDX_IRQ_EN: rdData[7:0] = irqEnable_ff;
        `IRFL_IDX_EXTRA_EN: rdData[4:0] = extraIrqEnable_ff;
        `IRFL_IDX_PRIO: rdData[7:0] = prio_ff;
        `IRFL_IDX_EXTRA_PRIO: rdData[4:0] = extraPrio_ff;
        `IRFL_IDX_EVT_STATUS: rdData[11:0] = evtStatus_ff;
        `IRFL_IDX_EVT_MASK: rdData[11:0] = evtMask_ff;
        `IRFL_IDX_PENDING: rdData[11:0] = gated;
        default: rdData = 32'h0000_0000;
    endcase
end

// one-cycle ack, one cycle after the request is seen
always @(posedge mclk) begin
    if (!rst_n) begin
        wbAckO <= 1'b0;
        wbDatO <= 32'h0000_0000;
    end else begin
        wbAckO <= busReq & ~wbAckO;
        if (busReq && !wbAckO) begin
            wbDatO <= rdData;
        end
    end
end
endmodule // irfl_core

/* File: tb/irfl_core_asserts.sv */
// port checker for the interrupt request flag logic
`timescale 1ns/1ps
module irfl_core_asserts (
    input wire mclk,
    input wire rst_n,
    input wire wbCycI,
    input wire wbStbI,
    input wire wbWeI,
    input wire [7:0] wbAdrI,
    input wire [3:0] wbSelI,
    input wire [31:0] wbDatI,
    input wire [31:0] wbDatO,
    input wire wbAckO,
    input wire [5:0] extIrqPinN,
    input wire timerAOvfI,
    input wire uartTxI,
    input wire watchdogTimeoutI,
    input wire irqReqO,
    input wire [3:0] irqSrcO,
    input wire [15:0] irqVecO,
    input wire irqO
);
reg [7:0] en_ff;
reg [7:0] xEn_ff;
reg gOld_ff;
reg [11:0] msk_ff;
reg mOld_ff;
wire wr = wbAckO && wbWeI;
wire [5:0] idx = wbAdrI[7:2];
wire hit = (timerAOvfI && en_ff[1]) || (uartTxI && en_ff[4])
    || (watchdogTimeoutI && xEn_ff[4]);
wire [15:0] expVec = 16'h0003 + {9'h000, irqSrcO + (irqSrcO >= 4'h6), 3'h0};
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
// shadow of enables and mask as written over the bus
always @(posedge mclk) begin
    if (!rst_n) begin
        en_ff <= 8'h00;
        xEn_ff <= 8'h00;
        msk_ff <= 12'h000;
    end else if (wr) begin
        if (idx == 6'h07 && wbSelI[0]) en_ff <= wbDatI[7:0];
        if (idx == 6'h08 && wbSelI[0]) xEn_ff <= wbDatI[7:0];
        if (idx == 6'h0c && wbSelI[1:0] == 2'b11) msk_ff <= wbDatI[11:0];
    end
    gOld_ff <= rst_n && en_ff[7];
    mOld_ff <= rst_n && (|msk_ff);
end
a_ack_next: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
    else $error("ack missing one cycle after request");
a_ack_pulse: assert property (wbAckO |=> !wbAckO)
    else $error("ack longer than one cycle");
a_unmapped_zero: assert property (
    wbAckO && !wbWeI && idx > 6'h0d |-> wbDatO == 32'h0000_0000)
    else $error("unmapped read not zero");
a_vector_match: assert property (
    irqReqO |-> irqSrcO <= 4'hb && irqVecO == expVec)
    else $error("vector does not match source");
a_global_block: assert property (!en_ff[7] && !gOld_ff |-> !irqReqO)
    else $error("request with global enable clear");
a_periph_req: assert property (
    hit && en_ff[7] && gOld_ff |-> ##2 irqReqO)
    else $error("enabled event gave no request");
a_ext_edge_req: assert property (
    $fell(extIrqPinN[2]) && en_ff[7] && xEn_ff[0] |-> ##[2:14] irqReqO)
    else $error("pin fall gave no request");
a_mask_quiet: assert property (msk_ff == 12'h000 && !mOld_ff |-> !irqO)
    else $error("irq output with all masked");
endmodule // irfl_core_asserts

/* File: tb/irfl_cpu_model.sv */
// processor core and pin sources facing the flag logic
`timescale 1ns/1ps
module irfl_cpu_model (
    input wire mclk,
    input wire rst_n,
    input wire [5:0] pinWant,
    input wire svcGo,
    input wire irqReqO,
    input wire [3:0] irqSrcO,
    output reg [5:0] extIrqPinN,
    output reg svcEnterI,
    output reg [3:0] svcSrcI
);
reg [3:0] hold_ff;
// pins move only after two machine cycles of hold
always @(posedge mclk) begin
    if (!rst_n) begin
        extIrqPinN <= 6'h3f;
        hold_ff <= 4'h0;
    end else if (pinWant != extIrqPinN && hold_ff >= 4'h8) begin
        extIrqPinN <= pinWant;
        hold_ff <= 4'h0;
    end else if (hold_ff != 4'hf) begin
        hold_ff <= hold_ff + 4'h1;
    end
end
// vector only to the winning pending source
always @(posedge mclk) begin
    svcEnterI <= svcGo && irqReqO && rst_n;
    svcSrcI <= irqSrcO;
end
endmodule // irfl_cpu_model

/* File: tb/irfl_core_tb.sv */
// self-checking bench for the interrupt request flag logic
`timescale 1ns/1ps
module irfl_core_tb;
logic mclk = 1'b0;
logic rst_n = 1'b0;
logic wbCycI = 1'b0;
logic wbStbI = 1'b0;
logic wbWeI = 1'b0;
logic [7:0] wbAdrI = 8'h00;
logic [3:0] wbSelI = 4'h0;
logic [31:0] wbDatI = 32'h0000_0000;
logic [8:0] ev = 9'h000;
logic [5:0] pinWant = 6'h3f;
logic svcGo = 1'b0;
wire [31:0] wbDatO;
wire wbAckO;
wire [5:0] extIrqPinN;
wire svcEnterI;
wire [3:0] svcSrcI;
wire irqReqO;
wire [3:0] irqSrcO;
wire [15:0] irqVecO;
wire irqO;
wire irqHighO;
wire [31:0] reqWord = {11'h000, irqReqO, irqSrcO, irqVecO};
logic [31:0] rd;
int mismatches = 0;
int samples_checked = 0;
int cyc = 0;
int evIdx[9] = '{0, 0, 3, 3, 6, 4, 4, 5, 5};
int evBit[9] = '{5, 7, 7, 6, 3, 0, 1, 0, 1};
int evSrc[9] = '{1, 3, 5, 5, 11, 4, 4, 6, 6};
int r;
int i;
int j;
int ac;
always #20 mclk = ~mclk;
irfl_core #(.CLKS_PER_MC(4)) irfl_core_inst (
    .mclk(mclk), .rst_n(rst_n), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .extIrqPinN(extIrqPinN),
    .timerAOvfI(ev[0]), .timerBOvfI(ev[1]), .counterCOvfI(ev[2]),
    .counterCCapI(ev[3]), .watchdogTimeoutI(ev[4]), .uartRxI(ev[5]),
    .uartTxI(ev[6]), .uart2RxI(ev[7]), .uart2TxI(ev[8]),
    .svcEnterI(svcEnterI), .svcSrcI(svcSrcI), .irqReqO(irqReqO),
    .irqSrcO(irqSrcO), .irqVecO(irqVecO), .irqHighO(irqHighO), .irqO(irqO));
irfl_cpu_model irfl_cpu_model_inst (
    .mclk(mclk), .rst_n(rst_n), .pinWant(pinWant), .svcGo(svcGo),
    .irqReqO(irqReqO), .irqSrcO(irqSrcO), .extIrqPinN(extIrqPinN),
    .svcEnterI(svcEnterI), .svcSrcI(svcSrcI));
// expected request word: source plus its vector
function logic [31:0] expReq(input int s);
    return {11'h000, 1'b1, 4'(s), 16'h0003 + 16'(8 * (s + (s >= 6)))};
endfunction
task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        mismatches++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
endtask
// one classic wishbone cycle, waits for ack
task wb(input logic we, input logic [5:0] ix, input logic [31:0] d);
    @(posedge mclk);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= {ix, 2'b00};
    wbSelI <= 4'hf;
    wbDatI <= d;
    @(posedge mclk);
    while (wbAckO !== 1'b1) @(posedge mclk);
    rd = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
endtask
task rchk(input logic [5:0] ix, input logic [31:0] exp);
    wb(1'b0, ix, 32'h0000_0000);
    chk(rd, exp);
endtask
task setEn(input int s);
    wb(1'b1, 6'h07, s < 7 ? 32'h0000_0080 | (32'h1 << s) : 32'h0000_0080);
    wb(1'b1, 6'h08, s < 7 ? 32'h0000_0000 : 32'h1 << (s - 7));
endtask
task pulse(input int k);
    @(posedge mclk);
    ev[k] <= 1'b1;
    @(posedge mclk);
    ev <= 9'h000;
endtask
task svc;
    @(posedge mclk);
    svcGo <= 1'b1;
    @(posedge mclk);
    svcGo <= 1'b0;
    repeat (3) @(posedge mclk);
endtask
task pin(input int k, input logic v);
    @(posedge mclk);
    pinWant[k] <= v;
    repeat (24) @(posedge mclk);
endtask
// cut a hang short
always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
        mismatches++;
        stop_test();
    end
end
// main sequence
initial begin
    r = $urandom(32'h0ef1);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rchk(6'h07, 32'h0000_0000);
    rchk(6'h20, 32'h0000_0000);
    r = $urandom % 9;
    for (i = 0; i < 9; i++) begin
        j = (i + r) % 9;
        setEn(evSrc[j]);
        pulse(j);
        repeat (2) @(posedge mclk);
        chk(reqWord, expReq(evSrc[j]));
        svc();
        rchk(evIdx[j], j < 2 ? 0 : 32'h1 << evBit[j]);
        wb(1'b1, evIdx[j], 32'h0000_0000);
        wb(1'b1, evIdx[j], 32'h1 << evBit[j]);
        repeat (3) @(posedge mclk);
        chk(reqWord, expReq(evSrc[j]));
        wb(1'b1, evIdx[j], 32'h0000_0000);
    end
    wb(1'b1, 6'h00, 32'h0000_0001);
    setEn(0);
    pin(0, 1'b0);
    chk(reqWord, expReq(0));
    rchk(6'h00, 32'h0000_0003);
    svc();
    rchk(6'h00, 32'h0000_0001);
    pin(0, 1'b1);
    setEn(2);
    pin(1, 1'b0);
    svc();
    rchk(6'h00, 32'h0000_0009);
    chk(reqWord, expReq(2));
    pin(1, 1'b1);
    rchk(6'h00, 32'h0000_0001);
    for (j = 2; j < 6; j++) begin
        ac = $urandom % 2;
        wb(1'b1, 6'h02, ac << (j + 2));
        setEn(j + 5);
        pin(j, 1'b0);
        rchk(6'h01, 32'h1 << (j + 2));
        svc();
        rchk(6'h01, ac ? 0 : 32'h1 << (j + 2));
        wb(1'b1, 6'h01, 32'h0000_0000);
        pin(j, 1'b1);
        rchk(6'h01, 32'h0000_0000);
    end
    wb(1'b1, 6'h07, 32'h0000_0098);
    wb(1'b1, 6'h04, 32'h0000_0001);
    wb(1'b1, 6'h00, 32'h0000_0080);
    repeat (3) @(posedge mclk);
    chk(reqWord, expReq(3));
    wb(1'b1, 6'h09, 32'h0000_0010);
    repeat (3) @(posedge mclk);
    chk(reqWord, expReq(4));
    chk({31'h0, irqHighO}, 32'h0000_0001);
    rchk(6'h0d, 32'h0000_0018);
    wb(1'b1, 6'h07, 32'h0000_0018);
    repeat (3) @(posedge mclk);
    chk({31'h0, irqReqO}, 32'h0000_0000);
    wb(1'b1, 6'h0c, 32'h0000_0fff);
    wb(1'b1, 6'h04, 32'h0000_0000);
    wb(1'b1, 6'h00, 32'h0000_0000);
    wb(1'b1, 6'h07, 32'h0000_0090);
    wb(1'b1, 6'h0b, 32'h0000_0fff);
    repeat (3) @(posedge mclk);
    chk({31'h0, irqO}, 32'h0000_0000);
    pulse(6);
    repeat (3) @(posedge mclk);
    chk({31'h0, irqO}, 32'h0000_0001);
    wb(1'b1, 6'h04, 32'h0000_0000);
    wb(1'b1, 6'h0b, 32'h0000_0fff);
    repeat (3) @(posedge mclk);
    chk({31'h0, irqO}, 32'h0000_0000);
    stop_test();
end
endmodule // irfl_core_tb
bind irfl_core irfl_core_asserts irfl_core_asserts_inst (.*);
